// [core/iof_pkg.sv]
// package of constants and types for the option-flags command block
package iof_pkg;

  // packet identifiers
  localparam logic [7:0] CMD_OPTIONS = 8'h35;
  localparam logic [7:0] RPT_OPTIONS = 8'h55;
  localparam logic [7:0] CMD_SUPER = 8'h8E;
  localparam logic [7:0] SUB_SAVE_CFG = 8'h26;

  // payload sizes
  localparam logic [2:0] LEN_QUERY = 3'h0;
  localparam logic [2:0] LEN_UPDATE = 3'h4;
  localparam logic [2:0] LEN_MAX = 3'h7;
  localparam logic [2:0] LAST_RPT_IDX = 3'h4;
  localparam int BYTE_W = 8;

  // register offsets and widths
  localparam int ADDR_W = 4;
  localparam logic [3:0] REG_OPTIONS = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;

  // option word: byte 0 in bits 7:0 up to byte 3 in bits 31:24
  localparam logic [31:0] OPT_DEFAULT = 32'h0201_0212;
  localparam logic [31:0] OPT_USED = 32'h031f_033f;

  typedef struct packed {
    logic [5:0] unused;
    logic smooth_code;
    logic raw_meas;
  } iof_aux_t;

  typedef struct packed {
    logic [2:0] unused;
    logic min_projection;
    logic sync_meas;
    logic on_request;
    logic next_second;
    logic utc_time;
  } iof_timing_t;

  typedef struct packed {
    logic [5:0] unused;
    logic local_east_north_up;
    logic earth_fixed_frame;
  } iof_vel_t;

  typedef struct packed {
    logic [1:0] unused;
    logic supp_fix;
    logic double_prec;
    logic alt_in_sea_level_height;
    logic alt_out_sea_level_height;
    logic geodetic_coordinates;
    logic cartesian_coordinates;
  } iof_pos_t;

  typedef struct packed {
    iof_aux_t aux;
    iof_timing_t timing;
    iof_vel_t vel;
    iof_pos_t pos;
  } iof_opts_t;

  // byte stream from and to the packet framer
  typedef struct packed {
    logic valid;
    logic first;
    logic last;
    logic [7:0] data;
  } iof_byte_t;

  typedef struct packed {
    logic [7:0] discards;
    logic [7:0] queries;
    logic [7:0] updates;
    logic [7:0] saves;
  } iof_count_t;

  typedef enum logic [1:0] {
    ST_INIT = 2'b00,
    ST_IDLE = 2'b01,
    ST_SEND = 2'b10
  } iof_state_t;

  typedef struct packed {
    iof_state_t st;
    iof_opts_t opts;
    logic [7:0] cmd;
    logic [2:0] cnt;
    logic [31:0] payload;
    logic [2:0] idx;
    iof_byte_t tx;
    logic rx_ready;
    logic save;
    logic [31:0] rdata;
    iof_count_t counts;
  } iof_regs_t;

  localparam iof_regs_t REGS_RESET = '{
    st: ST_INIT,
    opts: iof_opts_t'(OPT_DEFAULT),
    cmd: 8'h00,
    cnt: 3'h0,
    payload: 32'h0000_0000,
    idx: 3'h0,
    tx: '0,
    rx_ready: 1'b0,
    save: 1'b0,
    rdata: 32'h0000_0000,
    counts: '0
  };

endpackage : iof_pkg

// [core/iof_cmd.sv]
// option-flags command interpreter with report generator and register port
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module iof_cmd (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // command bytes from framer
  input wire iof_pkg::iof_byte_t rx,
  output logic rx_ready,
  // report bytes to framer
  output iof_pkg::iof_byte_t tx,
  input wire logic tx_ready,
  // nonvolatile store
  input wire logic nv_valid,
  input wire iof_pkg::iof_opts_t nv_opts,
  output logic nv_save,
  // option state to the navigation logic
  output iof_pkg::iof_opts_t opts,
  // register port
  input wire logic [iof_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);

  iof_pkg::iof_regs_t s_q;
  iof_pkg::iof_regs_t s_d;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic iof_pkg::iof_opts_t clean(input logic [31:0] v);
    clean = iof_pkg::iof_opts_t'(v & iof_pkg::OPT_USED);
  endfunction : clean

  function automatic logic [7:0] opt_byte(input logic [31:0] v,
                                          input logic [2:0] i);
    opt_byte = v[i[1:0]*iof_pkg::BYTE_W +: iof_pkg::BYTE_W];
  endfunction : opt_byte

  logic rx_take;
  logic end_opt;
  logic end_save;
  assign rx_take = rx.valid && s_q.rx_ready;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [7:0] cmd;
    logic [2:0] cnt;
    logic [31:0] pay;
    cmd = s_q.cmd;
    cnt = s_q.cnt;
    pay = s_q.payload;
    s_d = s_q;
    s_d.save = 1'b0;
    s_d.rdata = 32'h0000_0000;
    end_opt = 1'b0;
    end_save = 1'b0;

    // register port; packet updates below take priority
    if (reg_rd)
    begin
      unique case (reg_addr)
        iof_pkg::REG_OPTIONS: s_d.rdata = s_q.opts;
        iof_pkg::REG_STATUS: s_d.rdata = s_q.counts;
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
    if (reg_wr && reg_addr == iof_pkg::REG_OPTIONS)
      s_d.opts = clean(reg_wdata);

    // byte parser
    if (rx_take)
    begin
      if (rx.first)
      begin
        cmd = rx.data;
        cnt = iof_pkg::LEN_QUERY;
      end
      else
      begin
        if (cnt < iof_pkg::LEN_UPDATE)
          pay[cnt[1:0]*iof_pkg::BYTE_W +: iof_pkg::BYTE_W] = rx.data;
        if (cmd == iof_pkg::CMD_SUPER && cnt == iof_pkg::LEN_QUERY
            && rx.data == iof_pkg::SUB_SAVE_CFG && rx.last)
          end_save = 1'b1;
        if (cnt != iof_pkg::LEN_MAX)
          cnt = cnt + 3'h1;
      end
      if (rx.last && cmd == iof_pkg::CMD_OPTIONS)
        end_opt = 1'b1;
    end
    s_d.cmd = cmd;
    s_d.cnt = cnt;
    s_d.payload = pay;

    if (end_save)
    begin
      s_d.save = 1'b1;
      s_d.counts.saves = s_q.counts.saves + 8'h01;
    end

    if (end_opt)
    begin
      if (cnt == iof_pkg::LEN_QUERY)
      begin
        s_d.counts.queries = s_q.counts.queries + 8'h01;
      end
      else if (cnt == iof_pkg::LEN_UPDATE)
      begin
        s_d.opts = clean(pay);
        s_d.counts.updates = s_q.counts.updates + 8'h01;
      end
      else
        s_d.counts.discards = s_q.counts.discards + 8'h01;
    end

    unique case (s_q.st)
      iof_pkg::ST_INIT:
      begin
        if (nv_valid)
          s_d.opts = clean(nv_opts);
        s_d.st = iof_pkg::ST_IDLE;
        s_d.rx_ready = 1'b1;
      end
      iof_pkg::ST_IDLE:
      begin
        if (end_opt && (cnt == iof_pkg::LEN_QUERY
                        || cnt == iof_pkg::LEN_UPDATE))
        begin
          s_d.st = iof_pkg::ST_SEND;
          s_d.rx_ready = 1'b0;
          s_d.idx = 3'h0;
          s_d.tx = '{valid: 1'b1, first: 1'b1, last: 1'b0,
                     data: iof_pkg::RPT_OPTIONS};
        end
      end
      iof_pkg::ST_SEND:
      begin
        if (tx_ready)
        begin
          if (s_q.idx == iof_pkg::LAST_RPT_IDX)
          begin
            s_d.tx = '0;
            s_d.st = iof_pkg::ST_IDLE;
            s_d.rx_ready = 1'b1;
          end
          else
          begin
            s_d.idx = s_q.idx + 3'h1;
            s_d.tx.first = 1'b0;
            s_d.tx.last = (s_q.idx + 3'h1) == iof_pkg::LAST_RPT_IDX;
            s_d.tx.data = opt_byte(s_q.opts, s_q.idx);
          end
        end
      end
      default:
      begin
        s_d = iof_pkg::REGS_RESET;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      s_q <= iof_pkg::REGS_RESET;
    else
      s_q <= s_d;
  end

  assign rx_ready = s_q.rx_ready;
  assign tx = s_q.tx;
  assign nv_save = s_q.save;
  assign opts = s_q.opts;
  assign reg_rdata = s_q.rdata;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_query_keeps_opts: assert property (
    @(posedge mclk) disable iff (!rstn)
    end_opt && rx.first
      && !(reg_wr && reg_addr == iof_pkg::REG_OPTIONS)
      && s_q.st == iof_pkg::ST_IDLE
    |=> $stable(opts))
    else $error("query changed options");

  chk_update_loads_opts: assert property (
    @(posedge mclk) disable iff (!rstn)
    rx_take && rx.last && !rx.first && s_q.cmd == iof_pkg::CMD_OPTIONS
      && s_q.cnt == 3'h3 && s_q.st == iof_pkg::ST_IDLE
    |=> opts[31:24] == ($past(rx.data) & iof_pkg::OPT_USED[31:24])
        && opts[23:0] == ($past(s_q.payload[23:0])
                          & iof_pkg::OPT_USED[23:0]))
    else $error("update did not load options");

  chk_report_follows: assert property (
    @(posedge mclk) disable iff (!rstn)
    end_opt && s_q.st == iof_pkg::ST_IDLE
      && (s_d.cnt == iof_pkg::LEN_QUERY || s_d.cnt == iof_pkg::LEN_UPDATE)
    |=> tx.valid && tx.first && tx.data == iof_pkg::RPT_OPTIONS
        && !rx_ready)
    else $error("no report after option command");

  chk_report_last_byte: assert property (
    @(posedge mclk) disable iff (!rstn)
    tx.valid && tx.last && tx_ready |=> !tx.valid && rx_ready)
    else $error("report did not end cleanly");

  chk_save_pulse: assert property (
    @(posedge mclk) disable iff (!rstn)
    nv_save |=> !nv_save)
    else $error("save pulse longer than one cycle");

  chk_unused_zero: assert property (
    @(posedge mclk) disable iff (!rstn)
    (opts & ~iof_pkg::OPT_USED) == 32'h0000_0000)
    else $error("unused option bits set");

  chk_bad_len_kept: assert property (
    @(posedge mclk) disable iff (!rstn)
    end_opt && s_d.cnt != iof_pkg::LEN_QUERY
      && s_d.cnt != iof_pkg::LEN_UPDATE
      && !(reg_wr && reg_addr == iof_pkg::REG_OPTIONS)
      && s_q.st == iof_pkg::ST_IDLE
    |=> $stable(opts) && !tx.valid)
    else $error("bad length altered options");

  chk_reset_default: assert property (
    @(posedge mclk)
    !rstn |=> opts == iof_pkg::OPT_DEFAULT && !tx.valid && !rx_ready)
    else $error("reset did not load defaults");

  chk_init_stored: assert property (
    @(posedge mclk) disable iff (!rstn)
    s_q.st == iof_pkg::ST_INIT && nv_valid
    |=> opts == ($past(nv_opts) & iof_pkg::OPT_USED))
    else $error("stored options not loaded");

  chk_init_default: assert property (
    @(posedge mclk) disable iff (!rstn)
    s_q.st == iof_pkg::ST_INIT && !nv_valid && !reg_wr
    |=> opts == iof_pkg::OPT_DEFAULT)
    else $error("defaults lost without stored options");

  // ----------------------------------------------------------------
  // report stream checks
  // ----------------------------------------------------------------
  chk_report_advance: assert property (
    @(posedge mclk) disable iff (!rstn)
    tx.valid && tx_ready && !tx.last
    |=> tx.valid && !tx.first && !rx_ready)
    else $error("report stopped early");

  chk_report_holds: assert property (
    @(posedge mclk) disable iff (!rstn)
    tx.valid && !tx_ready |=> $stable(tx))
    else $error("report byte changed while stalled");

  chk_report_first_data: assert property (
    @(posedge mclk) disable iff (!rstn)
    tx.valid && tx.first && tx_ready
    |=> tx.data == $past(opts[7:0]))
    else $error("report byte 0 wrong");

  chk_busy_refuses: assert property (
    @(posedge mclk) disable iff (!rstn)
    tx.valid |-> !rx_ready)
    else $error("command bytes taken during report");

  chk_save_follows: assert property (
    @(posedge mclk) disable iff (!rstn)
    end_save |=> nv_save)
    else $error("save command gave no save pulse");

  // ----------------------------------------------------------------
  // register and counter checks
  // ----------------------------------------------------------------
  chk_write_masked: assert property (
    @(posedge mclk) disable iff (!rstn)
    reg_wr && reg_addr == iof_pkg::REG_OPTIONS && !rx_take
      && s_q.st != iof_pkg::ST_INIT
    |=> opts == ($past(reg_wdata) & iof_pkg::OPT_USED))
    else $error("option write not masked");

  chk_read_back: assert property (
    @(posedge mclk) disable iff (!rstn)
    reg_rd && reg_addr == iof_pkg::REG_OPTIONS
    |=> reg_rdata == $past(opts))
    else $error("option read back wrong");

  chk_query_counted: assert property (
    @(posedge mclk) disable iff (!rstn)
    end_opt && s_d.cnt == iof_pkg::LEN_QUERY
    |=> s_q.counts.queries == $past(s_q.counts.queries) + 8'h01)
    else $error("query not counted");

  chk_update_counted: assert property (
    @(posedge mclk) disable iff (!rstn)
    end_opt && s_d.cnt == iof_pkg::LEN_UPDATE
    |=> s_q.counts.updates == $past(s_q.counts.updates) + 8'h01)
    else $error("update not counted");

  chk_discard_counted: assert property (
    @(posedge mclk) disable iff (!rstn)
    end_opt && s_d.cnt != iof_pkg::LEN_QUERY
      && s_d.cnt != iof_pkg::LEN_UPDATE
    |=> s_q.counts.discards == $past(s_q.counts.discards) + 8'h01)
    else $error("discarded command not counted");

endmodule : iof_cmd

`default_nettype wire

// [core/iof_cmd_status_note.sv]
// note on the status word layout; the logic lives in iof_cmd
// discards 31:24, queries 23:16, updates 15:8, saves 7:0
// each count wraps at 8 bits

// [tb/iof_host.sv]
// host model: sends command packets and takes report bytes
`timescale 1ns/1ps
`default_nettype none

module iof_host (
  // clock
  input wire logic mclk,
  // command bytes
  output iof_pkg::iof_byte_t rx,
  input wire logic rx_ready,
  // report bytes
  input wire iof_pkg::iof_byte_t tx,
  output logic tx_ready
);
  logic slow = 1'b0;
  logic [9:0] got[$];

  initial rx = '0;
  initial tx_ready = 1'b1;

  // stall every other cycle when slow
  always @(posedge mclk)
  begin
    if (tx.valid && tx_ready)
      got.push_back({tx.first, tx.last, tx.data});
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end

  // each byte held until taken
  task automatic send(input logic [7:0] b[$]);
    for (int i = 0; i < b.size(); i++)
    begin
      rx <= '{1'b1, i == 0, i == b.size() - 1, b[i]};
      do @(posedge mclk); while (rx_ready !== 1'b1);
    end
    rx <= '{1'b0, 1'b0, 1'b0, ~b[b.size() - 1]};
  endtask : send
endmodule : iof_host
`default_nettype wire

// [tb/tb_top.sv]
// testbench for the option-flags command block
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic mclk;
  logic rstn;
  logic nv_valid;
  logic [31:0] nv_opts;
  logic nv_save;
  iof_pkg::iof_byte_t rx;
  iof_pkg::iof_byte_t tx;
  logic rx_ready;
  logic tx_ready;
  iof_pkg::iof_opts_t opts;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic [31:0] rd;
  int mismatches = 0;
  int cmp_count = 0;

  iof_cmd i_iof_cmd (.mclk(mclk), .rstn(rstn), .rx(rx), .rx_ready(rx_ready),
    .tx(tx), .tx_ready(tx_ready), .nv_valid(nv_valid), .nv_opts(nv_opts),
    .nv_save(nv_save), .opts(opts), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  iof_host i_iof_host (.mclk(mclk), .rx(rx), .rx_ready(rx_ready), .tx(tx),
    .tx_ready(tx_ready));

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic check(input string name, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize

  task automatic do_reset(input logic valid);
    nv_valid <= valid;
    rstn <= 1'b0;
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    repeat (3) @(posedge mclk);
  endtask : do_reset

  task automatic reg_read(input logic [3:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    // read data stand only in the cycle after the strobe
    @(negedge mclk);
    rd = reg_rdata;
    @(posedge mclk);
  endtask : reg_read

  // wait for the five report bytes and compare them
  task automatic report(input logic [31:0] v);
    int n;
    n = 0;
    while (i_iof_host.got.size() < 5 && n < 40)
    begin
      @(posedge mclk);
      n++;
    end
    check("report size", 32'(i_iof_host.got.size()), 32'h0000_0005);
    if (i_iof_host.got.size() == 5)
    begin
      check("report id", 32'(i_iof_host.got[0]), 32'h0000_0255);
      for (int k = 0; k < 4; k++)
        check("report byte", 32'(i_iof_host.got[k + 1]),
          {22'h0, 1'b0, k == 3, v[8 * k +: 8]});
    end
    i_iof_host.got.delete();
  endtask : report

  task automatic t_defaults;
    check("ready after reset", 32'(rx_ready), 32'h0000_0001);
    check("opts default", opts, 32'h0201_0212);
    reg_read(4'h0);
    check("reg default", rd, 32'h0201_0212);
    i_iof_host.send('{8'h35});
    report(32'h0201_0212);
    check("opts after query", opts, 32'h0201_0212);
    $display("test defaults done");
  endtask : t_defaults

  // every bit alone, unused ones included
  task automatic t_bits;
    logic [31:0] v;
    for (int i = 0; i < 32; i++)
    begin
      v = 32'h0000_0001 << i;
      i_iof_host.slow = i[0];
      i_iof_host.send('{8'h35, v[7:0], v[15:8], v[23:16], v[31:24]});
      report(v & 32'h031f_033f);
      check("opts bit", opts, v & 32'h031f_033f);
    end
    i_iof_host.slow = 1'b0;
    $display("test bits done");
  endtask : t_bits

  task automatic t_bad;
    logic [7:0] q[$];
    // payload lengths 1, 2, 3, 9 and 5, every byte all ones
    for (int n = 1; n < 6; n++)
    begin
      q = '{8'h35};
      repeat (n == 4 ? 9 : n) q.push_back(8'hff);
      i_iof_host.send(q);
      repeat (20) @(posedge mclk);
      check("no report", 32'(i_iof_host.got.size()), 32'h0000_0000);
      check("opts kept", opts, 32'h0000_0000);
    end
    $display("test bad lengths done");
  endtask : t_bad

  task automatic t_save;
    int hi;
    hi = 0;
    i_iof_host.send('{8'h8e, 8'h26});
    repeat (6)
    begin
      @(posedge mclk);
      hi += int'(nv_save === 1'b1);
    end
    check("save pulse", 32'(hi), 32'h0000_0001);
    $display("test save done");
  endtask : t_save

  task automatic t_regs;
    reg_addr <= 4'h0;
    reg_wdata <= 32'hffff_ffff;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_read(4'h0);
    check("reg options", rd, 32'h031f_033f);
    check("opts written", opts, 32'h031f_033f);
    reg_read(4'h8);
    check("reg unmapped", rd, 32'h0000_0000);
    reg_read(4'h4);
    check("reg status", rd, 32'h0501_2001);
    do_reset(1'b1);
    check("opts stored", opts, 32'h031f_033f);
    $display("test registers done");
  endtask : t_regs

  initial
  begin
    rstn = 1'b0;
    nv_valid = 1'b0;
    nv_opts = 32'hffff_ffff;
    reg_addr = 4'h0;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    do_reset(1'b0);
    t_defaults();
    t_bits();
    t_bad();
    t_save();
    t_regs();
    summarize();
  end

  initial
  begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    $display("watchdog expired");
    summarize();
  end
endmodule : tb_top
`default_nettype wire
